/* hw/gp_dma_pkg.sv */
package gp_dma_pkg;

   // Bus and counter widths.
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 24;
   localparam int BUF_DEPTH = 2;

   // Per-operand address and count steps.
   localparam logic [CNT_W-1:0] BYTE_STEP = 24'h000001;
   localparam logic [CNT_W-1:0] WORD_STEP = 24'h000002;
   localparam logic [1:0]       IDX_FIRST = 2'h0;
   localparam logic [1:0]       IDX_ONE   = 2'h1;
   localparam logic [1:0]       IDX_TWO   = 2'h2;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h000000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [7:0]       BYTE_ZERO = 8'h00;

   // Positions of the synchronised pin levels, all active high; every pin but grant is inverted.
   localparam int SYN_DTACK = 0;
   localparam int SYN_BERR  = 1;
   localparam int SYN_HALT  = 2;
   localparam int SYN_GRANT = 3;
   localparam int SYN_DREQ  = 4;
   localparam int SYN_W     = 5;

   // Transfer direction.
   typedef enum logic [1:0] {
      DIR_MEM_MEM = 2'h0,
      DIR_MEM_PER = 2'h1,
      DIR_PER_MEM = 2'h2
   } dir_t;

   // Channel sequencer states.
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_ARB   = 8'h02,
      ST_START = 8'h04,
      ST_WAIT  = 8'h08,
      ST_END   = 8'h10,
      ST_HOLD  = 8'h20,
      ST_PUSH  = 8'h40,
      ST_DONE  = 8'h80
   } state_t;

endpackage

/* hw/operand_buf_if.sv */
`timescale 1ns/1ps
interface operand_buf_if #(
   parameter int W = 16
);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport fill  (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
   modport store (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
endinterface

/* hw/operand_buffer.sv */
`timescale 1ns/1ps
module operand_buffer #(
   parameter int W     = 16,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic  clk,
   input wire logic  rst,
   // Buffer ports
   operand_buf_if.store b
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // The level is one bit wider than the pointers so a full buffer can be told from an empty one.
   localparam logic [PW:0] LEVEL_FULL = (PW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [PW:0]             level;
   } buf_state_t;

   buf_state_t r_reg;
   buf_state_t r_next;
   logic       do_in;
   logic       do_out;

   assign b.in_ready  = (r_reg.level != LEVEL_FULL);
   assign b.out_valid = (r_reg.level != '0);
   assign b.out_data  = r_reg.mem[r_reg.rp];
   assign do_in       = b.in_valid && b.in_ready;
   assign do_out      = b.out_valid && b.out_ready;

   always_comb begin
      r_next = r_reg;
      if (do_in) begin
         r_next.mem[r_reg.wp] = b.in_data;
         r_next.wp = (r_reg.wp == PW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
      end
      if (do_out) begin
         r_next.rp = (r_reg.rp == PW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
      end
      if (do_in && !do_out) begin
         r_next.level = r_reg.level + 1'b1;
      end else if (do_out && !do_in) begin
         r_next.level = r_reg.level - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

/* hw/general_purpose_dma.sv */
`timescale 1ns/1ps
// Overview of operation
// - Memory-memory, memory-peripheral, peripheral-memory directions.
// - Operands move as bytes or words.
// - Source and destination may start odd.
// - Each operand takes two to four bus cycles.
// - Both even word operands on a 16-bit bus: word read, then word write.
// - Any odd start splits into byte cycles.
// - Pack bytes into words, unpack words.
// - Honour halt, bus error and retry.
// - Up to 4 MBps at 16 MHz.
// - Data bus is 16 or 8 bits.
// - Protocol processor reaches local RAM without arbitration.
// - Source, destination pointers and byte counter programmable.
// - Three peripheral handshake lines: request, acknowledge, done.
// - Drives 24-bit address, 8/16-bit data.
module general_purpose_dma (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   // Channel programming
   input  wire logic                            start,
   input  wire logic [gp_dma_pkg::ADDR_W-1:0]   cfg_src,
   input  wire logic [gp_dma_pkg::ADDR_W-1:0]   cfg_dst,
   input  wire logic [gp_dma_pkg::CNT_W-1:0]    cfg_count,
   input  wire logic [1:0]                      cfg_dir,
   input  wire logic                            cfg_src_word,
   input  wire logic                            cfg_dst_word,
   input  wire logic                            bus_8bit,
   // Channel status
   output logic                                 busy,
   output logic                                 bus_error,
   output logic                                 done_pulse,
   // Arbitration with the serial channels and the bus
   input  wire logic                            serial_req,
   input  wire logic                            cp_ram_req,
   output logic                                 cp_ram_grant,
   output logic                                 bus_req,
   input  wire logic                            bus_grant,
   // System bus pins
   output logic [gp_dma_pkg::ADDR_W-1:0]        addr,
   output logic                                 bus_oe,
   output logic                                 as_n,
   output logic                                 uds_n,
   output logic                                 lds_n,
   output logic                                 rw,
   input  wire logic [gp_dma_pkg::DATA_W-1:0]   data_in,
   output logic [gp_dma_pkg::DATA_W-1:0]        data_out,
   output logic                                 data_oe,
   input  wire logic                            dtack_n,
   input  wire logic                            berr_n,
   input  wire logic                            halt_n,
   // Peripheral handshake pins
   input  wire logic                            dreq_n,
   output logic                                 dack_n,
   output logic                                 done_n
);
   typedef struct packed {
      gp_dma_pkg::state_t              st;
      gp_dma_pkg::state_t              after;
      logic [gp_dma_pkg::SYN_W-1:0]    sync1;
      logic [gp_dma_pkg::SYN_W-1:0]    sync2;
      logic [gp_dma_pkg::ADDR_W-1:0]   src;
      logic [gp_dma_pkg::ADDR_W-1:0]   dst;
      logic [gp_dma_pkg::CNT_W-1:0]    cnt;
      logic [1:0]                      dir;
      logic                            src_word;
      logic                            dst_word;
      logic                            bus8;
      logic                            rd;
      logic [1:0]                      idx;
      logic [gp_dma_pkg::DATA_W-1:0]   pack;
      logic [gp_dma_pkg::ADDR_W-1:0]   addr;
      logic                            bus_oe;
      logic                            as_n;
      logic                            uds_n;
      logic                            lds_n;
      logic                            rw;
      logic [gp_dma_pkg::DATA_W-1:0]   dout;
      logic                            doe;
      logic                            bus_req;
      logic                            dack_n;
      logic                            done_n;
      logic                            busy;
      logic                            err;
      logic                            done_p;
      logic                            cp_grant;
   } dma_state_t;

   dma_state_t r_reg;
   dma_state_t r_next;

   operand_buf_if #(.W(gp_dma_pkg::DATA_W)) ob ();

   operand_buffer #(
      .W     (gp_dma_pkg::DATA_W),
      .DEPTH (gp_dma_pkg::BUF_DEPTH)
   ) u_buf (
      .clk (clk),
      .rst (rst),
      .b   (ob.store)
   );

   // Synchronised pin levels.
   logic                            s_dtack;
   logic                            s_berr;
   logic                            s_halt;
   logic                            s_grant;
   logic                            s_dreq;
   // Geometry of the bus cycle about to run or running.
   logic [gp_dma_pkg::CNT_W-1:0]    op_len;
   logic                            unit_word;
   logic [gp_dma_pkg::ADDR_W-1:0]   cyc_addr;
   logic                            cyc_word;
   logic [1:0]                      idx_new;
   logic                            op_last;
   logic                            per_cycle;
   logic [7:0]                      rd_byte;
   logic [7:0]                      wr_byte;
   logic [gp_dma_pkg::DATA_W-1:0]   wr_data;

   assign s_dtack = r_reg.sync2[gp_dma_pkg::SYN_DTACK];
   assign s_berr  = r_reg.sync2[gp_dma_pkg::SYN_BERR];
   assign s_halt  = r_reg.sync2[gp_dma_pkg::SYN_HALT];
   assign s_grant = r_reg.sync2[gp_dma_pkg::SYN_GRANT];
   assign s_dreq  = r_reg.sync2[gp_dma_pkg::SYN_DREQ];

   // A word operand is set by either side; the narrower side packs or unpacks.
   assign op_len    = (r_reg.src_word || r_reg.dst_word) ?
                      gp_dma_pkg::WORD_STEP : gp_dma_pkg::BYTE_STEP;
   assign unit_word = r_reg.rd ? r_reg.src_word : r_reg.dst_word;
   assign cyc_addr  = (r_reg.rd ? r_reg.src : r_reg.dst) + {22'h000000, r_reg.idx};
   // A single word cycle needs a wide bus, an even address and a whole operand.
   assign cyc_word  = unit_word && !r_reg.bus8 && !cyc_addr[0] &&
                      (r_reg.idx == gp_dma_pkg::IDX_FIRST) &&
                      (op_len == gp_dma_pkg::WORD_STEP);
   assign idx_new   = r_reg.idx + (cyc_word ? gp_dma_pkg::IDX_TWO : gp_dma_pkg::IDX_ONE);
   assign op_last   = (idx_new == op_len[1:0]);
   assign per_cycle = r_reg.rd ? (r_reg.dir == gp_dma_pkg::DIR_PER_MEM) :
                                 (r_reg.dir == gp_dma_pkg::DIR_MEM_PER);

   // Even bytes ride the upper lane of a wide bus; a narrow bus uses the lower lane only.
   assign rd_byte = (r_reg.bus8 || cyc_addr[0]) ? data_in[7:0] : data_in[15:8];
   assign wr_byte = (r_reg.idx == gp_dma_pkg::IDX_FIRST) ? ob.out_data[15:8] : ob.out_data[7:0];
   assign wr_data = cyc_word ? ob.out_data :
                    (r_reg.bus8 ? {gp_dma_pkg::BYTE_ZERO, wr_byte} : {wr_byte, wr_byte});

   assign ob.in_valid  = (r_reg.st == gp_dma_pkg::ST_PUSH);
   assign ob.in_data   = r_reg.pack;
   assign ob.out_ready = (r_reg.st == gp_dma_pkg::ST_WAIT) && s_dtack && !s_berr &&
                         !r_reg.rd && op_last;

   always_comb begin
      r_next = r_reg;
      r_next.sync1 = {~dreq_n, bus_grant, ~halt_n, ~berr_n, ~dtack_n};
      r_next.sync2 = r_reg.sync1;
      // Local RAM accesses by the protocol processor never wait on this channel.
      r_next.cp_grant = cp_ram_req;
      r_next.done_p = 1'b0;
      r_next.done_n = 1'b1;
      unique case (r_reg.st)
         gp_dma_pkg::ST_IDLE: begin
            if (start) begin
               r_next.src      = cfg_src;
               r_next.dst      = cfg_dst;
               r_next.cnt      = cfg_count;
               r_next.dir      = cfg_dir;
               r_next.src_word = cfg_src_word;
               r_next.dst_word = cfg_dst_word;
               r_next.bus8     = bus_8bit;
               r_next.idx      = gp_dma_pkg::IDX_FIRST;
               r_next.rd       = 1'b1;
               r_next.err      = 1'b0;
               r_next.busy     = 1'b1;
               if (cfg_count == gp_dma_pkg::CNT_ZERO) begin
                  r_next.st = gp_dma_pkg::ST_DONE;
               end else begin
                  r_next.st = gp_dma_pkg::ST_ARB;
               end
            end
         end
         gp_dma_pkg::ST_ARB: begin
            // The request is withdrawn while any serial channel wants the bus.
            r_next.bus_req = !serial_req;
            if (r_reg.bus_req && s_grant && !serial_req) begin
               r_next.bus_oe = 1'b1;
               r_next.st     = gp_dma_pkg::ST_START;
            end
         end
         gp_dma_pkg::ST_START: begin
            if (serial_req) begin
               // Yield only between bus cycles so no cycle is cut short.
               r_next.bus_req = 1'b0;
               r_next.bus_oe  = 1'b0;
               r_next.st      = gp_dma_pkg::ST_ARB;
            end else if (s_halt || s_berr) begin
               r_next.st = gp_dma_pkg::ST_START;
            end else if (per_cycle && (r_reg.idx == gp_dma_pkg::IDX_FIRST) && !s_dreq) begin
               r_next.st = gp_dma_pkg::ST_START;
            end else if (r_reg.rd || ob.out_valid) begin
               r_next.addr   = cyc_addr;
               r_next.rw     = r_reg.rd;
               r_next.as_n   = 1'b0;
               r_next.uds_n  = r_reg.bus8 || (!cyc_word && cyc_addr[0]);
               r_next.lds_n  = !r_reg.bus8 && !cyc_word && !cyc_addr[0];
               r_next.dout   = r_reg.rd ? gp_dma_pkg::DATA_ZERO : wr_data;
               r_next.doe    = !r_reg.rd;
               r_next.dack_n = !per_cycle;
               r_next.st     = gp_dma_pkg::ST_WAIT;
            end
         end
         gp_dma_pkg::ST_WAIT: begin
            if (s_berr || s_dtack) begin
               r_next.as_n   = 1'b1;
               r_next.uds_n  = 1'b1;
               r_next.lds_n  = 1'b1;
               r_next.doe    = 1'b0;
               r_next.dack_n = 1'b1;
               r_next.st     = gp_dma_pkg::ST_END;
            end
            if (s_berr && s_halt) begin
               // Retry: nothing advances, the same cycle runs again after halt.
               r_next.after = gp_dma_pkg::ST_HOLD;
            end else if (s_berr) begin
               r_next.err   = 1'b1;
               r_next.after = gp_dma_pkg::ST_DONE;
            end else if (s_dtack && r_reg.rd) begin
               if (cyc_word) begin
                  r_next.pack = data_in;
               end else if (r_reg.idx == gp_dma_pkg::IDX_FIRST) begin
                  r_next.pack[15:8] = rd_byte;
               end else begin
                  r_next.pack[7:0] = rd_byte;
               end
               r_next.idx   = op_last ? gp_dma_pkg::IDX_FIRST : idx_new;
               r_next.after = op_last ? gp_dma_pkg::ST_PUSH : gp_dma_pkg::ST_START;
            end else if (s_dtack) begin
               r_next.idx = op_last ? gp_dma_pkg::IDX_FIRST : idx_new;
               r_next.after = gp_dma_pkg::ST_START;
               if (op_last) begin
                  r_next.rd = 1'b1;
                  // Peripheral ends keep a fixed address.
                  if (r_reg.dir != gp_dma_pkg::DIR_PER_MEM) begin
                     r_next.src = r_reg.src + op_len;
                  end
                  if (r_reg.dir != gp_dma_pkg::DIR_MEM_PER) begin
                     r_next.dst = r_reg.dst + op_len;
                  end
                  // A last word operand on an odd count still ends the block.
                  if (r_reg.cnt <= op_len) begin
                     r_next.cnt   = gp_dma_pkg::CNT_ZERO;
                     r_next.after = gp_dma_pkg::ST_DONE;
                  end else begin
                     r_next.cnt = r_reg.cnt - op_len;
                  end
               end
            end
         end
         gp_dma_pkg::ST_END: begin
            // The slave must drop its answer before the next cycle may start.
            if (!s_dtack && !s_berr) begin
               r_next.st = r_reg.after;
            end
         end
         gp_dma_pkg::ST_HOLD: begin
            if (!s_halt) begin
               r_next.st = gp_dma_pkg::ST_START;
            end
         end
         gp_dma_pkg::ST_PUSH: begin
            if (ob.in_ready) begin
               r_next.rd = 1'b0;
               r_next.st = gp_dma_pkg::ST_START;
            end
         end
         gp_dma_pkg::ST_DONE: begin
            r_next.bus_req = 1'b0;
            r_next.bus_oe  = 1'b0;
            r_next.busy    = 1'b0;
            r_next.done_p  = 1'b1;
            r_next.done_n  = 1'b0;
            r_next.st      = gp_dma_pkg::ST_IDLE;
         end
         default: begin
            r_next.st = gp_dma_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg        <= '0;
         r_reg.st     <= gp_dma_pkg::ST_IDLE;
         r_reg.after  <= gp_dma_pkg::ST_IDLE;
         r_reg.rd     <= 1'b1;
         r_reg.as_n   <= 1'b1;
         r_reg.uds_n  <= 1'b1;
         r_reg.lds_n  <= 1'b1;
         r_reg.rw     <= 1'b1;
         r_reg.dack_n <= 1'b1;
         r_reg.done_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign busy         = r_reg.busy;
   assign bus_error    = r_reg.err;
   assign done_pulse   = r_reg.done_p;
   assign cp_ram_grant = r_reg.cp_grant;
   assign bus_req      = r_reg.bus_req;
   assign addr         = r_reg.addr;
   assign bus_oe       = r_reg.bus_oe;
   assign as_n         = r_reg.as_n;
   assign uds_n        = r_reg.uds_n;
   assign lds_n        = r_reg.lds_n;
   assign rw           = r_reg.rw;
   assign data_out     = r_reg.dout;
   assign data_oe      = r_reg.doe;
   assign dack_n       = r_reg.dack_n;
   assign done_n       = r_reg.done_n;
endmodule

/* verification/dma_monitor.sv */
`timescale 1ns/1ps
module dma_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched ports
   input wire logic start,
   input wire logic busy,
   input wire logic bus_error,
   input wire logic done_pulse,
   input wire logic done_n,
   input wire logic serial_req,
   input wire logic cp_ram_req,
   input wire logic cp_ram_grant,
   input wire logic bus_grant,
   input wire logic bus_oe,
   input wire logic as_n,
   input wire logic uds_n,
   input wire logic rw,
   input wire logic data_oe,
   input wire logic dtack_n,
   input wire logic bus_8bit,
   input wire logic dack_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   owner_strobe_a: assert property (!as_n |-> bus_oe)
      else $error("address strobe low without bus ownership");
   grant_first_a: assert property ($rose(bus_oe) |-> $past(bus_grant, 3))
      else $error("bus taken before grant");
   serial_yield_a: assert property ((serial_req [*2]) ##0 !bus_oe |=> !bus_oe)
      else $error("bus taken while serial channel requests");
   write_drive_a: assert property (data_oe |-> !rw && bus_oe)
      else $error("data driven outside a write cycle");
   narrow_lane_a: assert property (bus_8bit && !as_n |-> uds_n)
      else $error("upper lane used on narrow bus");
   dtack_end_a: assert property (!dtack_n && !as_n |-> ##[1:5] as_n)
      else $error("cycle not ended after acknowledge");
   done_once_a: assert property (done_pulse |=> !done_pulse)
      else $error("completion pulse too long");
   done_line_a: assert property ($fell(done_n) |=> done_n)
      else $error("done line low too long");
   start_busy_a: assert property (start && !busy |=> busy)
      else $error("start not taken");
   error_sticky_a: assert property (bus_error && !start |=> bus_error)
      else $error("error flag lost");
   ram_direct_a: assert property (cp_ram_req |=> cp_ram_grant)
      else $error("local RAM grant late");
   dack_bus_a: assert property (!dack_n |-> bus_oe)
      else $error("acknowledge outside own cycle");
endmodule

/* verification/sys_bus_model.sv */
`timescale 1ns/1ps
module sys_bus_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Pins from the channel
   input  wire logic [23:0] addr,
   input  wire logic        as_n,
   input  wire logic        uds_n,
   input  wire logic        lds_n,
   input  wire logic        rw,
   input  wire logic [15:0] data_out,
   input  wire logic        bus_req,
   // Answers to the channel
   output logic [15:0]      data_in,
   output logic             dtack_n,
   output logic             berr_n,
   output logic             halt_n,
   output logic             bus_grant,
   // Bench control
   input  wire logic        narrow,
   input  wire logic [3:0]  wait_cyc,
   input  wire logic [1:0]  fault
);
   logic [7:0] mem [0:255];
   logic [3:0] cnt;
   logic       acked;
   logic       served;
   logic [7:0] a;
   logic [7:0] ev;
   assign a = addr[7:0];
   assign ev = {addr[7:1], 1'b0};
   // Undriven read data toggles so a stale value never looks valid.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         {dtack_n, berr_n, halt_n} <= 3'h7;
         {bus_grant, acked, served} <= 3'h0;
         cnt <= 4'h0;
         data_in <= 16'h0000;
      end else begin
         bus_grant <= bus_req;
         if (fault == 2'h0) served <= 1'b0;
         if (as_n) begin
            {dtack_n, berr_n, halt_n} <= 3'h7;
            cnt <= 4'h0;
            acked <= 1'b0;
            data_in <= ~data_in;
         end else if (!acked) begin
            data_in <= ~data_in;
            cnt <= cnt + 4'h1;
            if (cnt >= wait_cyc) begin
               acked <= 1'b1;
               if (fault == 2'h1) begin
                  berr_n <= 1'b0;
               end else if (fault == 2'h2 && !served) begin
                  {berr_n, halt_n} <= 2'h0;
                  served <= 1'b1;
               end else begin
                  dtack_n <= 1'b0;
                  if (rw && narrow) data_in <= {~mem[a], mem[a]};
                  else if (rw) data_in <= {mem[ev], mem[ev | 8'h01]};
                  else if (narrow) mem[a] <= data_out[7:0];
                  else begin
                     if (!uds_n) mem[ev] <= data_out[15:8];
                     if (!lds_n) mem[ev | 8'h01] <= data_out[7:0];
                  end
               end
            end
         end
      end
   end
endmodule

/* verification/general_purpose_dma_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module general_purpose_dma_tb;
   logic clk = 0, rst = 1, start = 0, sw = 0, dw = 0, nb = 0, serial_req = 0;
   logic cp_ram_req = 0, cp_ram_grant, bus_req, bus_grant, busy, bus_error, done_pulse;
   logic [23:0] cfg_src = 24'h000000, cfg_dst = 24'h000000, cfg_count = 24'h000000, addr;
   logic [1:0] cfg_dir = 2'h0, fault = 2'h0;
   logic [3:0] wait_cyc = 4'h0;
   logic bus_oe, as_n, uds_n, lds_n, rw, data_oe, dtack_n, berr_n, halt_n;
   logic dreq_n = 0, dack_n, done_n;
   logic [15:0] data_in, data_out;
   int failures = 0, checks = 0, ncyc = 0, nack = 0;
   always #5 clk = ~clk;
   always @(negedge as_n) ncyc++;
   always @(negedge dack_n) nack++;
   general_purpose_dma dut_u (.clk(clk), .rst(rst), .start(start), .cfg_src(cfg_src),
      .cfg_dst(cfg_dst), .cfg_count(cfg_count), .cfg_dir(cfg_dir), .cfg_src_word(sw),
      .cfg_dst_word(dw), .bus_8bit(nb), .busy(busy), .bus_error(bus_error),
      .done_pulse(done_pulse), .serial_req(serial_req), .cp_ram_req(cp_ram_req),
      .cp_ram_grant(cp_ram_grant), .bus_req(bus_req), .bus_grant(bus_grant), .addr(addr),
      .bus_oe(bus_oe), .as_n(as_n), .uds_n(uds_n), .lds_n(lds_n), .rw(rw), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .dtack_n(dtack_n), .berr_n(berr_n),
      .halt_n(halt_n), .dreq_n(dreq_n), .dack_n(dack_n), .done_n(done_n));
   sys_bus_model bus_u (.clk(clk), .rst(rst), .addr(addr), .as_n(as_n), .uds_n(uds_n),
      .lds_n(lds_n), .rw(rw), .data_out(data_out), .bus_req(bus_req), .data_in(data_in),
      .dtack_n(dtack_n), .berr_n(berr_n), .halt_n(halt_n), .bus_grant(bus_grant),
      .narrow(nb), .wait_cyc(wait_cyc), .fault(fault));
   task automatic wrap_up();
      if (failures == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic run(input logic [23:0] s, d, c, input logic [1:0] dr,
                      input logic w1, w2, n, input int ncy);
      int i;
      for (i = 0; i < 256; i++) bus_u.mem[i] = i[7:0] ^ 8'hA5;
      {cfg_src, cfg_dst, cfg_count, cfg_dir, sw, dw, nb} = {s, d, c, dr, w1, w2, n};
      ncyc = 0;
      nack = 0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      i = 0;
      while (done_pulse !== 1'b1 && i < 3000) begin
         @(negedge clk);
         i++;
      end
      if (i == 3000) begin
         failures++;
         wrap_up();
      end
      if (ncy >= 0) `CHK("bus cycles", ncy, ncyc)
      @(negedge clk);
   endtask
   task automatic copied(input logic [7:0] s, d, input int n);
      for (int i = 0; i < n; i++) `CHK("dst byte", s + i[7:0] ^ 8'hA5, bus_u.mem[d + i[7:0]])
   endtask
   task automatic t_modes();
      run(24'h10, 24'h40, 24'h4, 2'h0, 1, 1, 0, 4);
      copied(8'h10, 8'h40, 4);
      run(24'h20, 24'h50, 24'h3, 2'h0, 0, 0, 0, 6);
      copied(8'h20, 8'h50, 3);
      run(24'h11, 24'h60, 24'h4, 2'h0, 1, 1, 0, 6);
      copied(8'h11, 8'h60, 4);
      run(24'h30, 24'h71, 24'h4, 2'h0, 1, 1, 0, 6);
      copied(8'h30, 8'h71, 4);
      run(24'h22, 24'h80, 24'h4, 2'h0, 0, 1, 0, 6);
      copied(8'h22, 8'h80, 4);
      run(24'h24, 24'h90, 24'h4, 2'h0, 1, 0, 0, 6);
      copied(8'h24, 8'h90, 4);
      run(24'h26, 24'hA0, 24'h4, 2'h0, 1, 1, 1, 8);
      copied(8'h26, 8'hA0, 4);
   endtask
   task automatic t_periph();
      run(24'h28, 24'hB1, 24'h3, 2'h1, 0, 0, 0, 6);
      `CHK("fixed dst", 8'h2A ^ 8'hA5, bus_u.mem[8'hB1])
      `CHK("dst acks", 3, nack)
      dreq_n = 1'b1;
      fork
         run(24'hB3, 24'hC0, 24'h2, 2'h2, 0, 0, 0, 4);
         begin
            repeat (30) @(negedge clk);
            `CHK("held for request", 0, ncyc)
            dreq_n = 1'b0;
         end
      join
      `CHK("src acks", 2, nack)
      copied(8'hB3, 8'hC0, 1);
      `CHK("fixed src", 8'hB3 ^ 8'hA5, bus_u.mem[8'hC1])
   endtask
   task automatic t_faults();
      fault = 2'h2;
      run(24'h10, 24'h40, 24'h2, 2'h0, 1, 1, 0, 3);
      copied(8'h10, 8'h40, 2);
      `CHK("no error", 1'b0, bus_error)
      fault = 2'h1;
      run(24'h10, 24'h40, 24'h4, 2'h0, 1, 1, 0, 1);
      `CHK("error flag", 1'b1, bus_error)
      fault = 2'h0;
   endtask
   task automatic t_serial_busy();
      serial_req = 1'b1;
      wait_cyc = 4'h6;
      fork
         run(24'h12, 24'hD0, 24'h4, 2'h0, 1, 1, 0, 4);
         begin
            repeat (20) @(negedge clk);
            `CHK("bus held back", 1'b0, bus_oe)
            {serial_req, cp_ram_req} = 2'h1;
            @(negedge clk);
            cp_ram_req = 1'b0;
            repeat (4) @(negedge clk);
            {start, cfg_src} = {1'b1, 24'h000050};
            @(negedge clk);
            start = 1'b0;
         end
      join
      copied(8'h12, 8'hD0, 4);
      wait_cyc = 4'h0;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_modes();
      t_periph();
      t_faults();
      t_serial_busy();
      wrap_up();
   end
endmodule
bind general_purpose_dma dma_monitor mon_u (.clk(clk), .rst(rst), .start(start), .busy(busy),
   .bus_error(bus_error), .done_pulse(done_pulse), .done_n(done_n), .serial_req(serial_req),
   .cp_ram_req(cp_ram_req), .cp_ram_grant(cp_ram_grant), .bus_grant(bus_grant),
   .bus_oe(bus_oe), .as_n(as_n), .uds_n(uds_n), .rw(rw), .data_oe(data_oe),
   .dtack_n(dtack_n), .bus_8bit(bus_8bit), .dack_n(dack_n));
